// ---- smb_slave.sv ----
// Bus slave engine and open-drain status pin control
`timescale 1ns/1ps
module smb_slave #(
    parameter int HUNG_CYCLES = smb_pkg::HUNG_CYCLES // Both-low time before bus reset
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic scl, // Bus clock from the host, link domain
    input wire logic sda_in, // Data line level
    output logic sda_out, // Data line drive value, always low
    output logic sda_oe, // Data line pull-down enable
    input wire logic [1:0] address_select_strap, // Strap level code
    input wire logic sealed_lead_acid_type, // Battery type strap
    input wire logic shutdown_input, // Shutdown pin level
    input wire logic uvlo, // Undervoltage lockout level
    input wire smb_pkg::ind_s indicators, // Active-low status conditions
    input wire logic [2:0] pin_in, // Pin levels
    output logic [2:0] pin_out, // Pin drive values, always low
    output logic [2:0] pin_oe, // Pin pull-down enables
    output logic [2:0] pin_in_status, // Sampled pin levels
    output smb_pkg::pin_cfg_s pin_cfg, // Current pin configuration
    output logic forced_mode, // Power-up status mode active
    output smb_pkg::cmd_s cmd, // Command strobe to charger control
    output logic bus_active // Transfer in progress
);

    typedef struct packed {
        logic [1:0] init;
        logic forced;
        logic [6:0] addr7;
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic cap_m, cap_s;
        logic [2:0] pin_m, pin_s;
        logic shut_m, shut_s, uvlo_m, uvlo_s;
        logic lead_acid_m, lead_acid_s;
        logic [1:0] strap_m, strap_s;
        logic rise_p;
        smb_pkg::bus_st_e st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [1:0] bidx;
        logic [7:0] cmd;
        logic [7:0] dlo;
        logic want;
        logic [smb_pkg::HUNG_W-1:0] hung;
        smb_pkg::pin_cfg_s cfg;
        smb_pkg::cmd_s cmdout;
        logic [2:0] oe;
    } st_s;

    st_s q, n;
    logic [1:0] rsync_q;
    logic rst_s_n;
    logic cap_q;
    logic drive_q;
    logic start, stop;
    logic [15:0] word;
    logic [7:0] tx;
    logic [2:0] stat;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [6:0] addr7_of(input logic [1:0] s);
        unique case (s)
            smb_pkg::STRAP_VDD: addr7_of = smb_pkg::ADDR8_VDD[7:1];
            smb_pkg::STRAP_VREF: addr7_of = smb_pkg::ADDR8_VREF[7:1];
            default: addr7_of = smb_pkg::ADDR8_GND[7:1];
        endcase
    endfunction

    function automatic smb_pkg::pin_cfg_s cfg_default(input logic f);
        cfg_default.en = {3{f}};
        cfg_default.sel = {3{f}};
        cfg_default.out = 3'h0;
    endfunction

    function automatic logic [7:0] tx_byte(input logic [15:0] w, input logic [1:0] i);
        if (i == 2'h0) begin
            tx_byte = w[7:0];
        end else if (i == smb_pkg::BIDX_DATA_LO) begin
            tx_byte = w[15:8];
        end else begin
            tx_byte = 8'h00;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and link-domain flops

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_s_n = rsync_q[1];

    // Bit taken at the rising edge; stable for the whole high time
    always_ff @(posedge scl or negedge rst_s_n) begin
        if (!rst_s_n) begin
            cap_q <= 1'b0;
        end else begin
            cap_q <= sda_in;
        end
    end

    // The drive intent is settled long before the falling edge samples it
    always_ff @(negedge scl or negedge rst_s_n) begin
        if (!rst_s_n) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= q.want;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n = q;
        n.scl_m = scl;
        n.scl_s = q.scl_m;
        n.scl_p = q.scl_s;
        n.sda_m = sda_in;
        n.sda_s = q.sda_m;
        n.sda_p = q.sda_s;
        n.cap_m = cap_q;
        n.cap_s = q.cap_m;
        n.pin_m = pin_in;
        n.pin_s = q.pin_m;
        n.shut_m = shutdown_input;
        n.shut_s = q.shut_m;
        n.uvlo_m = uvlo;
        n.uvlo_s = q.uvlo_m;
        n.lead_acid_m = sealed_lead_acid_type;
        n.lead_acid_s = q.lead_acid_m;
        n.strap_m = address_select_strap;
        n.strap_s = q.strap_m;
        n.cmdout.valid = 1'b0;
        // One cycle late so the captured bit has crossed as well
        n.rise_p = q.scl_s & ~q.scl_p;
        start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
        stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
        word = 16'h0000;
        if (q.cmd == smb_pkg::CMD_PIN_CTRL) begin
            word = {smb_pkg::WORD_PAD, q.cfg};
        end else if (q.cmd == smb_pkg::CMD_PIN_STATUS) begin
            word = {smb_pkg::STAT_PAD, q.lead_acid_s, q.shut_s, q.forced, q.pin_s};
        end
        tx = tx_byte(word, q.bidx);

        // Strap is taken once, after the synchronisers have filled
        if (q.init != smb_pkg::INIT_DONE) begin
            n.init = q.init + 2'h1;
            if (q.init == smb_pkg::INIT_LATCH) begin
                n.forced = (q.strap_s == smb_pkg::STRAP_HALF_VREF);
                n.addr7 = addr7_of(q.strap_s);
                n.cfg = cfg_default(n.forced);
            end
        end

        // Only a long both-low state counts; no other timeouts exist
        if (!q.scl_s && !q.sda_s) begin
            n.hung = q.hung + 1'b1;
        end else begin
            n.hung = '0;
        end

        if (q.shut_s || q.init != smb_pkg::INIT_DONE) begin
            n.st = smb_pkg::ST_IDLE;
            n.want = 1'b0;
        end else if (start || stop) begin
            n.st = start ? smb_pkg::ST_ADDR : smb_pkg::ST_IDLE;
            n.bitcnt = 4'h0;
            n.bidx = 2'h0;
            n.want = 1'b0;
        end else if (q.hung == smb_pkg::HUNG_W'(HUNG_CYCLES - 1)) begin
            n.st = smb_pkg::ST_IDLE;
            n.want = 1'b0;
            n.hung = '0;
        end else if (q.rise_p) begin
            unique case (q.st)
                smb_pkg::ST_IDLE: begin
                    n.want = 1'b0;
                end
                smb_pkg::ST_ADDR: begin
                    if (q.bitcnt != smb_pkg::ACK_SLOT) begin
                        n.shreg = {q.shreg[6:0], q.cap_s};
                        n.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == smb_pkg::BIT_LAST) begin
                            n.want = (q.shreg[6:0] == q.addr7);
                        end
                    end else begin
                        n.bitcnt = 4'h0;
                        if (q.shreg[7:1] != q.addr7) begin
                            n.st = smb_pkg::ST_IDLE;
                            n.want = 1'b0;
                        end else if (q.shreg[0]) begin
                            n.st = smb_pkg::ST_RD;
                            n.shreg = tx;
                            n.want = ~tx[7];
                            n.bidx = smb_pkg::BIDX_DATA_LO;
                        end else begin
                            n.st = smb_pkg::ST_WR;
                            n.want = 1'b0;
                        end
                    end
                end
                smb_pkg::ST_WR: begin
                    if (q.bitcnt != smb_pkg::ACK_SLOT) begin
                        n.shreg = {q.shreg[6:0], q.cap_s};
                        n.bitcnt = q.bitcnt + 4'h1;
                        if (q.bitcnt == smb_pkg::BIT_LAST) begin
                            n.want = 1'b1;
                        end
                    end else begin
                        n.bitcnt = 4'h0;
                        n.want = 1'b0;
                        if (q.bidx != smb_pkg::BIDX_MAX) begin
                            n.bidx = q.bidx + 2'h1;
                        end
                        if (q.bidx == 2'h0) begin
                            n.cmd = q.shreg;
                        end else if (q.bidx == smb_pkg::BIDX_DATA_LO) begin
                            n.dlo = q.shreg;
                        end else if (q.bidx == smb_pkg::BIDX_DATA_HI) begin
                            n.cmdout.valid = 1'b1;
                            n.cmdout.code = q.cmd;
                            n.cmdout.data = {q.shreg, q.dlo};
                            if (q.cmd == smb_pkg::CMD_PIN_CTRL) begin
                                n.cfg = smb_pkg::pin_cfg_s'({q.shreg[0], q.dlo});
                            end
                        end
                    end
                end
                smb_pkg::ST_RD: begin
                    if (q.bitcnt == smb_pkg::ACK_SLOT) begin
                        n.bitcnt = 4'h0;
                        if (q.cap_s) begin
                            n.st = smb_pkg::ST_IDLE;
                            n.want = 1'b0;
                        end else begin
                            n.shreg = tx;
                            n.want = ~tx[7];
                            if (q.bidx != smb_pkg::BIDX_MAX) begin
                                n.bidx = q.bidx + 2'h1;
                            end
                        end
                    end else begin
                        n.bitcnt = q.bitcnt + 4'h1;
                        n.shreg = {q.shreg[6:0], 1'b0};
                        // Release for the host's acknowledge; otherwise pull low when the next bit is 0
                        n.want = (q.bitcnt == smb_pkg::BIT_LAST) ? 1'b0 : ~q.shreg[6];
                    end
                end
            endcase
        end

        // Bus resets leave the pin setup alone
        if (q.init == smb_pkg::INIT_DONE && (q.shut_s || q.uvlo_s)) begin
            n.cfg = cfg_default(q.forced);
        end

        stat[0] = q.lead_acid_s ? ~indicators.taper_reached_indicator_n
            : ~indicators.charging_indicator_n;
        stat[1] = ~indicators.backup_fault_indicator_n;
        stat[2] = q.forced ? ~indicators.charge_fault_indicator_n
            : ~indicators.calibration_done_indicator_n;
        for (int i = 0; i < smb_pkg::NPINS; i++) begin
            if (!q.cfg.en[i]) begin
                n.oe[i] = 1'b0;
            end else if (q.cfg.sel[i]) begin
                n.oe[i] = stat[i];
            end else begin
                n.oe[i] = ~q.cfg.out[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sda_out = 1'b0;
    assign sda_oe = drive_q;
    assign pin_out = 3'h0;
    assign pin_oe = q.oe;
    assign pin_in_status = q.pin_s;
    assign pin_cfg = q.cfg;
    assign forced_mode = q.forced;
    assign cmd = q.cmdout;
    assign bus_active = (q.st != smb_pkg::ST_IDLE);

endmodule // smb_slave

// ---- smb_pkg.sv ----
// Constants, types and state layout for the bus slave and status pins
package smb_pkg;
    localparam int CLK_MHZ = 100;
    localparam int HUNG_TIME_US = 1000;
    localparam int HUNG_CYCLES = HUNG_TIME_US * CLK_MHZ;
    localparam int HUNG_W = 20;
    localparam int NPINS = 3;
    localparam logic [7:0] ADDR8_GND = 8'h12;
    localparam logic [7:0] ADDR8_VDD = 8'h28;
    localparam logic [7:0] ADDR8_VREF = 8'h20;
    localparam logic [7:0] CMD_PIN_CTRL = 8'h3C;
    localparam logic [7:0] CMD_PIN_STATUS = 8'h3D;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] BIDX_DATA_LO = 2'h1;
    localparam logic [1:0] BIDX_DATA_HI = 2'h2;
    localparam logic [1:0] BIDX_MAX = 2'h3;
    localparam logic [1:0] INIT_LATCH = 2'h2;
    localparam logic [1:0] INIT_DONE = 2'h3;
    localparam logic [6:0] WORD_PAD = 7'h00;
    localparam logic [9:0] STAT_PAD = 10'h000;

    typedef enum logic [1:0] {
        STRAP_GND = 2'h0,
        STRAP_VDD = 2'h1,
        STRAP_VREF = 2'h2,
        STRAP_HALF_VREF = 2'h3
    } strap_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDR = 2'h1,
        ST_WR = 2'h3,
        ST_RD = 2'h2
    } bus_st_e;

    typedef struct packed {
        logic [2:0] sel;
        logic [2:0] out;
        logic [2:0] en;
    } pin_cfg_s;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic charging_indicator_n;
        logic taper_reached_indicator_n;
        logic backup_fault_indicator_n;
        logic charge_fault_indicator_n;
        logic calibration_done_indicator_n;
    } ind_s;
endpackage

// ---- smb_slave_monitor.sv ----
// Concurrent checks on the bus slave ports
`timescale 1ns/1ps
module smb_slave_monitor (
    input wire logic clk, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic scl, // Bus clock
    input wire logic sda_out, // Data drive value
    input wire logic sda_oe, // Data pull-down enable
    input wire logic sealed_lead_acid_type, // Battery type strap
    input wire smb_pkg::ind_s indicators, // Status conditions
    input wire logic [2:0] pin_out, // Pin drive values
    input wire logic [2:0] pin_oe, // Pin pull-down enables
    input wire smb_pkg::pin_cfg_s pin_cfg, // Pin configuration
    input wire logic forced_mode, // Power-up status mode
    input wire smb_pkg::cmd_s cmd // Command strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    a_open_drain_only: assert property (pin_out == 3'h0 && !sda_out)
        else $error("line driven high");
    a_disabled_release: assert property (!pin_cfg.en[0] |=> !pin_oe[0])
        else $error("disabled pin still pulled");
    // Strap is synchronised first, so it must have settled before pin 1 is judged
    a_pin1_status: assert property ($stable(sealed_lead_acid_type) [*4]
        ##0 (pin_cfg.en[0] && pin_cfg.sel[0]) |=> pin_oe[0] == ($past(sealed_lead_acid_type)
        ? !$past(indicators.taper_reached_indicator_n)
        : !$past(indicators.charging_indicator_n)))
        else $error("pin 1 status wrong");
    a_pin2_status: assert property (pin_cfg.en[1] && pin_cfg.sel[1]
        |=> pin_oe[1] == !$past(indicators.backup_fault_indicator_n))
        else $error("pin 2 status wrong");
    a_pin3_status: assert property (pin_cfg.en[2] && pin_cfg.sel[2] |=> pin_oe[2] ==
        ($past(forced_mode) ? !$past(indicators.charge_fault_indicator_n)
        : !$past(indicators.calibration_done_indicator_n)))
        else $error("pin 3 status wrong");
    a_pin_out_value: assert property (pin_cfg.en[2] && !pin_cfg.sel[2]
        |=> pin_oe[2] == !$past(pin_cfg.out[2])) else $error("pin 3 output value wrong");
    a_cmd_one_pulse: assert property (cmd.valid |=> !cmd.valid)
        else $error("command strobe longer than one cycle");
    a_sda_on_fall: assert property ($changed(sda_oe) |-> $fell(scl))
        else $error("data drive changed off the falling clock edge");
    c_command: cover property (cmd.valid);
    c_forced: cover property ($rose(forced_mode));
    c_answer: cover property ($rose(sda_oe));
endmodule // smb_slave_monitor

// ---- smb_host_model.sv ----
// Bus master model that drives frames toward the slave
`timescale 1ns/1ps
module smb_host_model (
    output logic scl, // Bus clock, stands high outside frames
    output logic sda_oe, // High while the host pulls the data line low
    input wire logic sda // Resolved data line
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // One eighth of the 256 ns link period; a phase spans 4 ticks for the sync latency
    task automatic tick(input int n);
        repeat (n) #32;
    endtask
    task automatic start_c();
        sda_oe = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b1;
        tick(4);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop_c();
        sda_oe = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_oe = 1'b0;
        tick(4);
    endtask
    task automatic hold_low(input int n);
        sda_oe = 1'b1;
        tick(n);
        sda_oe = 1'b0;
    endtask
    // Eight bits then the acknowledge slot; seen[0] is the acknowledge level
    task automatic xfer(input logic [7:0] d, input logic a, output logic [8:0] seen);
        logic [8:0] v;
        v = {d, a};
        for (int i = 8; i >= 0; i--) begin
            sda_oe = !v[i];
            tick(2);
            scl = 1'b1;
            tick(4);
            seen[i] = sda;
            scl = 1'b0;
            tick(2);
        end
    endtask
endmodule // smb_host_model

// ---- smb_slave_tb.sv ----
// Self-checking bench for the bus slave and status pins
`timescale 1ns/1ps
`define check(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module smb_slave_tb;
    localparam int HUNG = 200;
    logic clk = 1'b0, rst_n = 1'b0, lead_acid = 1'b0, shut = 1'b0, uvlo = 1'b0;
    logic [1:0] strap = 2'h0;
    smb_pkg::ind_s ind = 5'h1F;
    logic [2:0] pin_ext = 3'h7, pin_out, pin_oe, pin_st;
    smb_pkg::pin_cfg_s cfg;
    smb_pkg::cmd_s cmd;
    logic forced, busy, scl, host_oe, sda_oe, sda_out;
    int fail_count = 0, n_tests = 0, pulses = 0;
    wire logic sda_line = !(sda_oe || host_oe);
    wire logic [2:0] pin_in = pin_ext & ~pin_oe;
    always #5 clk = ~clk;
    always @(posedge clk) if (cmd.valid === 1'b1) pulses++;
    smb_slave #(.HUNG_CYCLES(HUNG)) u_smb_slave (.clk(clk), .rst_n(rst_n), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_strap(strap),
        .sealed_lead_acid_type(lead_acid), .shutdown_input(shut), .uvlo(uvlo), .indicators(ind),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_status(pin_st),
        .pin_cfg(cfg), .forced_mode(forced), .cmd(cmd), .bus_active(busy));
    smb_host_model u_host (.scl(scl), .sda_oe(host_oe), .sda(sda_line));
    ////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic [1:0] s);
        rst_n = 1'b0;
        strap = s;
        wait_clk(2);
        rst_n = 1'b1;
        wait_clk(12);
    endtask
    task automatic wr_word(input logic [7:0] a8, c, input logic [15:0] v, output logic [3:0] ak);
        logic [8:0] s;
        logic [7:0] b [4];
        b = '{a8, c, v[7:0], v[15:8]};
        u_host.start_c();
        for (int i = 0; i < 4; i++) begin
            u_host.xfer(b[i], 1'b1, s);
            ak[3 - i] = s[0];
        end
        u_host.stop_c();
    endtask
    task automatic rd_word(input logic [7:0] c, output logic [15:0] v);
        logic [8:0] s;
        u_host.start_c();
        u_host.xfer(8'h12, 1'b1, s);
        u_host.xfer(c, 1'b1, s);
        u_host.start_c();
        u_host.xfer(8'h13, 1'b1, s);
        u_host.xfer(8'hFF, 1'b0, s);
        v[7:0] = s[8:1];
        u_host.xfer(8'hFF, 1'b1, s);
        v[15:8] = s[8:1];
        u_host.stop_c();
    endtask
    task automatic t_address();
        logic [7:0] adr [3];
        logic [3:0] ak;
        int p;
        adr = '{8'h12, 8'h28, 8'h20};
        for (int i = 0; i < 3; i++) begin
            do_reset(2'(i));
            p = pulses;
            wr_word(adr[i], 8'h15, 16'hA5C3, ak);
            `check("ack", 4'h0, ak)
            `check("pulse", p + 1, pulses)
            wr_word(adr[(i + 1) % 3], 8'h15, 16'hA5C3, ak);
            `check("foreign ack", 4'hF, ak)
            `check("cfg", 9'h000, cfg)
        end
    endtask
    task automatic t_forced();
        logic [3:0] ak;
        logic [4:0] pat [4];
        logic [2:0] exp [4];
        do_reset(2'h3);
        `check("forced", 1'b1, forced)
        `check("cfg", 9'h1C7, cfg)
        pat = '{5'h0D, 5'h0D, 5'h16, 5'h1B};
        exp = '{3'h5, 3'h4, 3'h1, 3'h2};
        for (int i = 0; i < 4; i++) begin
            ind = pat[i];
            lead_acid = (i > 0);
            wait_clk(6);
            `check("pin_oe", exp[i], pin_oe)
        end
        lead_acid = 1'b0;
        wr_word(8'h12, 8'h15, 16'h0000, ak);
        `check("ack", 4'h0, ak)
    endtask
    task automatic t_program();
        logic [3:0] ak;
        logic [15:0] v;
        int p;
        do_reset(2'h0);
        ind = 5'h0D;
        p = pulses;
        wr_word(8'h12, smb_pkg::CMD_PIN_CTRL, 16'h0057, ak);
        `check("pulse", p + 1, pulses)
        `check("cmd", {8'h3C, 16'h0057}, {cmd.code, cmd.data})
        `check("cfg", 9'h057, cfg)
        `check("pin_oe", 3'h5, pin_oe)
        wait_clk(1);
        ind = 5'h1D;
        wait_clk(4);
        `check("pin_oe", 3'h4, pin_oe)
        `check("pin_in_status", 3'h3, pin_st)
        rd_word(smb_pkg::CMD_PIN_CTRL, v);
        `check("read ctrl", 16'h0057, v)
        rd_word(smb_pkg::CMD_PIN_STATUS, v);
        `check("read status", 16'h0003, v)
        wr_word(8'h12, smb_pkg::CMD_PIN_CTRL, 16'h01F8, ak);
        wait_clk(2);
        `check("pin_oe", 3'h0, pin_oe)
    endtask
    task automatic t_bus_resets();
        logic [8:0] s;
        logic [3:0] ak;
        u_host.start_c();
        u_host.xfer(8'h12, 1'b1, s);
        u_host.stop_c();
        `check("busy", 1'b0, busy)
        `check("cfg", 9'h1F8, cfg)
        u_host.start_c();
        u_host.xfer(8'h12, 1'b1, s);
        wr_word(8'h12, smb_pkg::CMD_PIN_CTRL, 16'h0057, ak);
        `check("restart", {4'h0, 9'h057}, {ak, cfg})
        u_host.start_c();
        u_host.xfer(8'h12, 1'b1, s);
        `check("busy", 1'b1, busy)
        u_host.hold_low(HUNG * 10 / 32 + 8);
        `check("busy", 1'b0, busy)
        u_host.stop_c();
    endtask
    task automatic t_power();
        logic [3:0] ak;
        wait_clk(1);
        shut = 1'b1;
        wait_clk(6);
        `check("cfg", 9'h000, cfg)
        wr_word(8'h12, 8'h15, 16'h0000, ak);
        `check("ack", 4'hF, ak)
        wait_clk(1);
        shut = 1'b0;
        wait_clk(6);
        wr_word(8'h12, smb_pkg::CMD_PIN_CTRL, 16'h0057, ak);
        `check("ack", {4'h0, 9'h057}, {ak, cfg})
        wait_clk(1);
        uvlo = 1'b1;
        wait_clk(6);
        `check("cfg", 9'h000, cfg)
        uvlo = 1'b0;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        t_address();
        t_forced();
        t_program();
        t_bus_resets();
        t_power();
        end_of_test();
    end
    // Roughly six times the expected run
    initial begin
        #1000000;
        fail_count++;
        end_of_test();
    end
endmodule // smb_slave_tb
bind smb_slave smb_slave_monitor u_mon (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_out(sda_out), .sda_oe(sda_oe), .sealed_lead_acid_type(sealed_lead_acid_type),
    .indicators(indicators), .pin_out(pin_out), .pin_oe(pin_oe), .pin_cfg(pin_cfg),
    .forced_mode(forced_mode), .cmd(cmd));
